// ---- design/dbgma_map.vh ----
// constants for the debug memory-access command block
// Operation
// - register read: opcode, address nibble, address, size
// - register read sends 1-256 bytes, zero means 256
// - register read returns ffh when locked out
// - program write: opcode, address, size, data bytes
// - memory sizes 1-65536, zero size means 65536
// - program write discarded unless flash unlocked
// - memory writes discarded outside debug or protected
// - program read returns data or ffh when locked out
// - data write: opcode, address, size, then data bytes
// - page select shares address with sector protect
// - 512-byte pages, erase uses page select bits
// - unlock steps locked, first, second, unlocked
// - debugger unlock skips second page select write
`ifndef DBGMA_MAP_VH
`define DBGMA_MAP_VH

// ==========================================================
// command opcodes
`define DBGMA_OP_RD_REG   8'h09
`define DBGMA_OP_WR_PROG  8'h0a
`define DBGMA_OP_RD_PROG  8'h0b
`define DBGMA_OP_WR_DATA  8'h0c
`define DBGMA_FILL_BYTE   8'hff

// ==========================================================
// apb register offsets (byte addresses)
`define DBGMA_REG_CTRL    12'h000
`define DBGMA_REG_FCTL    12'h004
`define DBGMA_REG_PGSEL   12'h008
`define DBGMA_REG_STAT    12'h00c

// ==========================================================
// ctrl fields and reset values
`define DBGMA_CTRL_DEBUG  0
`define DBGMA_CTRL_RPROT  1
`define DBGMA_CTRL_RST    2'h0
`define DBGMA_PGSEL_RST   8'h00
`define DBGMA_SPROT_RST   8'h00

// ==========================================================
// flash controller codes
`define DBGMA_UNLOCK1     8'h73
`define DBGMA_UNLOCK2     8'h8c
`define DBGMA_SECT_SEL    8'h5e
`define DBGMA_PAGE_ERASE  8'h95
`define DBGMA_FS_LOCKED   6'h00
`define DBGMA_FS_FIRST    6'h01
`define DBGMA_FS_SECOND   6'h02
`define DBGMA_FS_UNLOCKED 6'h03
`define DBGMA_FS_SECTOR   6'h04
`define DBGMA_PAGE_BITS   9

// ==========================================================
// memory spaces on the access port
`define DBGMA_SP_REG      2'h0
`define DBGMA_SP_PROG     2'h1
`define DBGMA_SP_DATA     2'h2

`endif

// ---- design/dbgma_fifo.v ----
// fifo with registered read data for reply bytes
`timescale 1ns/1ps
`default_nettype none
module dbgma_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32
) (
	// clock and reset
	input  wire             i_mclk,
	input  wire             i_nrst,
	// fill side
	input  wire [WIDTH-1:0] i_in_data,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	// drain side
	output reg  [WIDTH-1:0] o_out_data,
	output reg              o_out_valid,
	input  wire             i_out_ready
);
	function integer clog2;
		input integer v;
		integer n;
		begin
			n = 0;
			while ((1 << n) < v)
				n = n + 1;
			clog2 = (n < 1) ? 1 : n;
		end
	endfunction

	localparam AW = clog2(DEPTH);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr_ff;
	reg [AW-1:0]    rptr_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            load;

	assign o_in_ready = (cnt_ff < DEPTH[AW:0]);
	assign push       = i_in_valid && o_in_ready;
	// refill the output stage whenever it empties or is taken
	assign load       = (cnt_ff != {(AW+1){1'b0}}) &&
	                    (!o_out_valid || i_out_ready);

	always @(posedge i_mclk) begin
		if (push)
			mem[wptr_ff] <= i_in_data;
	end

	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			wptr_ff     <= {AW{1'b0}};
			rptr_ff     <= {AW{1'b0}};
			cnt_ff      <= {(AW+1){1'b0}};
			o_out_data  <= {WIDTH{1'b0}};
			o_out_valid <= 1'b0;
		end else begin
			if (push)
				wptr_ff <= wptr_ff + {{(AW-1){1'b0}}, 1'b1};
			if (load) begin
				o_out_data  <= mem[rptr_ff];
				o_out_valid <= 1'b1;
				rptr_ff     <= rptr_ff + {{(AW-1){1'b0}}, 1'b1};
			end else if (i_out_ready) begin
				o_out_valid <= 1'b0;
			end
			if (push && !load)
				cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
			else if (load && !push)
				cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

// ---- design/dbgma_core.v ----
// debug memory-access command interpreter with apb flash control
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dbgma_map.vh"
module dbgma_core #(
	parameter FIFO_DEPTH = 32
) (
	// clock and reset
	input  wire        i_mclk,
	input  wire        i_nrst,
	// apb slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	// command bytes from the debug link
	input  wire [7:0]  i_rx_data,
	input  wire        i_rx_valid,
	output wire        o_rx_ready,
	// reply bytes to the debug link
	output wire [7:0]  o_tx_data,
	output wire        o_tx_valid,
	input  wire        i_tx_ready,
	// memory access port
	output reg         o_mem_req,
	output reg         o_mem_we,
	output reg  [1:0]  o_mem_space,
	output reg  [15:0] o_mem_addr,
	output reg  [7:0]  o_mem_wdata,
	input  wire [7:0]  i_mem_rdata,
	input  wire        i_mem_ack,
	// flash page erase
	output reg         o_erase_req,
	output reg  [15:0] o_erase_addr
);
	// ==========================================================
	// command states
	localparam ST_IDLE    = 3'h0;
	localparam ST_HDR     = 3'h1;
	localparam ST_RD_MEM  = 3'h2;
	localparam ST_RD_PUSH = 3'h3;
	localparam ST_WR_GET  = 3'h4;
	localparam ST_WR_MEM  = 3'h5;

	// ==========================================================
	// functions
	// zero size stands for the full range of the field
	function [16:0] size_count;
		input [15:0] raw;
		input        wide;
		begin
			if (raw == 16'h0000)
				size_count = wide ? 17'h10000 : 17'h00100;
			else
				size_count = {1'b0, raw};
		end
	endfunction

	// register file addresses wrap inside twelve bits
	function [15:0] next_addr;
		input [15:0] a;
		input        reg_space;
		reg   [15:0] s;
		begin
			s = a + 16'h0001;
			next_addr = reg_space ? {4'h0, s[11:0]} : s;
		end
	endfunction

	// ==========================================================
	// registers
	reg [2:0]  st_ff;
	reg [2:0]  nxt_st;
	reg [7:0]  op_ff;
	reg [7:0]  nxt_op;
	reg [1:0]  hdr_idx_ff;
	reg [1:0]  nxt_hdr_idx;
	reg [15:0] addr_ff;
	reg [15:0] nxt_addr;
	reg [7:0]  size_hi_ff;
	reg [7:0]  nxt_size_hi;
	reg [16:0] cnt_ff;
	reg [16:0] nxt_cnt;
	reg [7:0]  byte_ff;
	reg [7:0]  nxt_byte;
	reg        req_ff;
	reg        nxt_req;
	reg [1:0]  ctrl_ff;
	reg [7:0]  pgsel_ff;
	reg [7:0]  sprot_ff;
	reg [5:0]  fstat_ff;
	reg [5:0]  nxt_fstat;
	reg [7:0]  nxt_pgsel;
	reg [7:0]  nxt_sprot;
	reg        nxt_erase;

	wire       debug_on;
	wire       locked_out;
	wire       unlocked;
	wire       is_reg_op;
	wire       last_hdr;
	wire       wr_allowed;
	wire       fifo_in_valid;
	wire       fifo_in_ready;
	wire       apb_setup;
	wire       apb_wr;
	wire       addr_hit;
	wire [7:0] wbyte;

	assign debug_on   = ctrl_ff[`DBGMA_CTRL_DEBUG];
	assign locked_out = !debug_on || ctrl_ff[`DBGMA_CTRL_RPROT];
	assign unlocked   = (fstat_ff == `DBGMA_FS_UNLOCKED);
	assign is_reg_op  = (op_ff == `DBGMA_OP_RD_REG);
	// register read has three header bytes, the rest four
	assign last_hdr   = is_reg_op ? (hdr_idx_ff == 2'd2) :
	                                (hdr_idx_ff == 2'd3);
	assign wr_allowed = !locked_out &&
	                    ((op_ff == `DBGMA_OP_WR_DATA) ||
	                     unlocked);

	// new bytes are only taken as opcodes from idle
	assign o_rx_ready = (st_ff == ST_IDLE) || (st_ff == ST_HDR) ||
	                    (st_ff == ST_WR_GET);
	assign fifo_in_valid = (st_ff == ST_RD_PUSH);

	// ==========================================================
	// command interpreter next state
	always @* begin
		nxt_st      = st_ff;
		nxt_op      = op_ff;
		nxt_hdr_idx = hdr_idx_ff;
		nxt_addr    = addr_ff;
		nxt_size_hi = size_hi_ff;
		nxt_cnt     = cnt_ff;
		nxt_byte    = byte_ff;
		nxt_req     = req_ff;
		case (st_ff)
		ST_IDLE: begin
			// unknown opcodes are dropped
			if (i_rx_valid && (i_rx_data == `DBGMA_OP_RD_REG ||
			    i_rx_data == `DBGMA_OP_WR_PROG ||
			    i_rx_data == `DBGMA_OP_RD_PROG ||
			    i_rx_data == `DBGMA_OP_WR_DATA)) begin
				nxt_op      = i_rx_data;
				nxt_hdr_idx = 2'd0;
				nxt_st      = ST_HDR;
			end
		end
		ST_HDR: begin
			if (i_rx_valid) begin
				nxt_hdr_idx = hdr_idx_ff + 2'd1;
				case (hdr_idx_ff)
				2'd0: begin
					if (is_reg_op)
						nxt_addr[15:8] = {4'h0, i_rx_data[3:0]};
					else
						nxt_addr[15:8] = i_rx_data;
				end
				2'd1:    nxt_addr[7:0] = i_rx_data;
				2'd2:    nxt_size_hi   = i_rx_data;
				default: nxt_size_hi   = size_hi_ff;
				endcase
				if (last_hdr) begin
					if (is_reg_op)
						nxt_cnt = size_count({8'h00, i_rx_data}, 1'b0);
					else
						nxt_cnt = size_count({size_hi_ff, i_rx_data},
						                     1'b1);
					if (is_reg_op || op_ff == `DBGMA_OP_RD_PROG)
						nxt_st = ST_RD_MEM;
					else
						nxt_st = ST_WR_GET;
				end
			end
		end
		ST_RD_MEM: begin
			if (locked_out && !req_ff) begin
				nxt_byte = `DBGMA_FILL_BYTE;
				nxt_st   = ST_RD_PUSH;
			end else if (!req_ff) begin
				nxt_req = 1'b1;
			end else if (i_mem_ack) begin
				nxt_req  = 1'b0;
				nxt_byte = i_mem_rdata;
				nxt_st   = ST_RD_PUSH;
			end
		end
		ST_RD_PUSH: begin
			// a full reply fifo stalls the read here
			if (fifo_in_ready) begin
				nxt_cnt  = cnt_ff - 17'h00001;
				nxt_addr = next_addr(addr_ff, is_reg_op);
				nxt_st   = (cnt_ff == 17'h00001) ? ST_IDLE : ST_RD_MEM;
			end
		end
		ST_WR_GET: begin
			if (i_rx_valid) begin
				nxt_byte = i_rx_data;
				if (wr_allowed) begin
					nxt_req = 1'b1;
					nxt_st  = ST_WR_MEM;
				end else begin
					// byte consumed but never stored
					nxt_cnt  = cnt_ff - 17'h00001;
					nxt_addr = next_addr(addr_ff, 1'b0);
					if (cnt_ff == 17'h00001)
						nxt_st = ST_IDLE;
				end
			end
		end
		ST_WR_MEM: begin
			if (i_mem_ack) begin
				nxt_req  = 1'b0;
				nxt_cnt  = cnt_ff - 17'h00001;
				nxt_addr = next_addr(addr_ff, 1'b0);
				nxt_st   = (cnt_ff == 17'h00001) ? ST_IDLE : ST_WR_GET;
			end
		end
		default: nxt_st = ST_IDLE;
		endcase
	end

	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff      <= ST_IDLE;
			op_ff      <= 8'h00;
			hdr_idx_ff <= 2'd0;
			addr_ff    <= 16'h0000;
			size_hi_ff <= 8'h00;
			cnt_ff     <= 17'h00000;
			byte_ff    <= 8'h00;
			req_ff     <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			op_ff      <= nxt_op;
			hdr_idx_ff <= nxt_hdr_idx;
			addr_ff    <= nxt_addr;
			size_hi_ff <= nxt_size_hi;
			cnt_ff     <= nxt_cnt;
			byte_ff    <= nxt_byte;
			req_ff     <= nxt_req;
		end
	end

	// ==========================================================
	// memory port, held steady while a request is open
	always @* begin
		o_mem_req   = req_ff;
		o_mem_we    = (st_ff == ST_WR_MEM);
		o_mem_addr  = addr_ff;
		o_mem_wdata = byte_ff;
		if (is_reg_op)
			o_mem_space = `DBGMA_SP_REG;
		else if (op_ff == `DBGMA_OP_WR_DATA)
			o_mem_space = `DBGMA_SP_DATA;
		else
			o_mem_space = `DBGMA_SP_PROG;
	end

	dbgma_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_reply_fifo (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.i_in_data   (byte_ff),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.o_out_data  (o_tx_data),
		.o_out_valid (o_tx_valid),
		.i_out_ready (i_tx_ready)
	);

	// ==========================================================
	// apb slave, zero wait states
	assign apb_setup = i_psel && !i_penable;
	assign apb_wr    = i_psel && i_penable && i_pwrite;
	assign wbyte     = i_pwdata[7:0];
	assign o_pready  = 1'b1;
	assign addr_hit  = (i_paddr == `DBGMA_REG_CTRL) ||
	                   (i_paddr == `DBGMA_REG_FCTL) ||
	                   (i_paddr == `DBGMA_REG_PGSEL) ||
	                   (i_paddr == `DBGMA_REG_STAT);
	assign o_pslverr = i_psel && i_penable && !addr_hit;

	// ==========================================================
	// flash unlock sequence and page select
	always @* begin
		nxt_fstat = fstat_ff;
		nxt_pgsel = pgsel_ff;
		nxt_sprot = sprot_ff;
		nxt_erase = 1'b0;
		if (apb_wr && i_paddr == `DBGMA_REG_FCTL) begin
			case (fstat_ff)
			`DBGMA_FS_LOCKED:
				if (wbyte == `DBGMA_UNLOCK1)
					nxt_fstat = `DBGMA_FS_FIRST;
			`DBGMA_FS_FIRST: begin
				if (wbyte == `DBGMA_UNLOCK2)
					nxt_fstat = `DBGMA_FS_SECOND;
				else
					nxt_fstat = `DBGMA_FS_LOCKED;
			end
			`DBGMA_FS_UNLOCKED: begin
				// one page per unlock, so any command relocks
				nxt_erase = (wbyte == `DBGMA_PAGE_ERASE);
				nxt_fstat = `DBGMA_FS_LOCKED;
			end
			default: nxt_fstat = `DBGMA_FS_LOCKED;
			endcase
		end else if (apb_wr && i_paddr == `DBGMA_REG_PGSEL) begin
			if (fstat_ff == `DBGMA_FS_SECTOR) begin
				nxt_sprot = wbyte;
				nxt_fstat = `DBGMA_FS_UNLOCKED;
			end else if (unlocked && wbyte == `DBGMA_SECT_SEL) begin
				nxt_fstat = `DBGMA_FS_SECTOR;
			end else begin
				nxt_pgsel = wbyte;
				if (fstat_ff == `DBGMA_FS_SECOND)
					nxt_fstat = `DBGMA_FS_UNLOCKED;
			end
		end else if (fstat_ff == `DBGMA_FS_SECOND && debug_on) begin
			nxt_fstat = `DBGMA_FS_UNLOCKED;
		end
	end

	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_ff      <= `DBGMA_CTRL_RST;
			pgsel_ff     <= `DBGMA_PGSEL_RST;
			sprot_ff     <= `DBGMA_SPROT_RST;
			fstat_ff     <= `DBGMA_FS_LOCKED;
			o_erase_req  <= 1'b0;
			o_erase_addr <= 16'h0000;
			o_prdata     <= 32'h00000000;
		end else begin
			fstat_ff    <= nxt_fstat;
			pgsel_ff    <= nxt_pgsel;
			sprot_ff    <= nxt_sprot;
			o_erase_req <= nxt_erase;
			if (nxt_erase)
				o_erase_addr <= {pgsel_ff[6:0],
				                 {`DBGMA_PAGE_BITS{1'b0}}};
			if (apb_wr && i_paddr == `DBGMA_REG_CTRL)
				ctrl_ff <= i_pwdata[1:0];
			// read data is caught in the setup cycle
			if (apb_setup) begin
				if (i_paddr == `DBGMA_REG_CTRL)
					o_prdata <= {30'h0, ctrl_ff};
				else if (i_paddr == `DBGMA_REG_FCTL)
					o_prdata <= {26'h0, fstat_ff};
				else if (i_paddr == `DBGMA_REG_PGSEL)
					o_prdata <= (fstat_ff == `DBGMA_FS_SECTOR) ?
					            {24'h0, sprot_ff} : {24'h0, pgsel_ff};
				else if (i_paddr == `DBGMA_REG_STAT)
					o_prdata <= {25'h0, fifo_in_ready, st_ff,
					             unlocked, locked_out, (st_ff != ST_IDLE)};
				else
					o_prdata <= 32'h00000000;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/dbgma_core_asserts.sv ----
// port checker for the debug memory-access core
`timescale 1ns/1ps
`default_nettype none
module dbgma_core_asserts (
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic        i_rx_valid,
	input wire logic        o_rx_ready,
	input wire logic [7:0]  o_tx_data,
	input wire logic        o_tx_valid,
	input wire logic        i_tx_ready,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [1:0]  o_mem_space,
	input wire logic [15:0] o_mem_addr,
	input wire logic [7:0]  o_mem_wdata,
	input wire logic        i_mem_ack,
	input wire logic        o_erase_req,
	input wire logic [15:0] o_erase_addr
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	// ============
	// memory port
	req_hold_a: assert property (
		o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
		&& $stable(o_mem_wdata)) else $error("request moved");
	ack_drop_a: assert property (
		o_mem_req && i_mem_ack |=> !o_mem_req) else $error("req after ack");
	busy_norx_a: assert property (
		o_mem_req |-> !o_rx_ready) else $error("rx open in access");
	wr_space_a: assert property (
		o_mem_req && o_mem_we |-> o_mem_space inside {2'h1, 2'h2})
		else $error("write to register file");
	wr_next_a: assert property (
		o_mem_req && o_mem_we && i_mem_ack |=> o_rx_ready)
		else $error("rx shut after write");
	wr_cause_a: assert property (
		$rose(o_mem_req) && o_mem_we |-> $past(i_rx_valid && o_rx_ready))
		else $error("write without byte");
	// ============
	// reply and erase
	tx_hold_a: assert property (
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("reply byte moved");
	erase_page_a: assert property (
		o_erase_req |-> o_erase_addr[8:0] == 9'h000 ##1 !o_erase_req)
		else $error("bad erase pulse");
endmodule
bind dbgma_core dbgma_core_asserts dbgma_core_asserts_i (.*);
`default_nettype wire

// ---- tb/dbgma_mem_model.sv ----
// memory partner on the core's access port, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module dbgma_mem_model (
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	input  wire logic        i_slow,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [1:0]  i_space,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata,
	output logic             o_ack,
	output int               o_nwr,
	output logic      [15:0] o_waddr,
	output logic      [7:0]  o_wdata
);
	int wait_ff;
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ack   <= 1'b0;
			o_nwr   <= 0;
			o_rdata <= 8'h00;
			wait_ff <= 0;
		end else if (i_req && !o_ack && wait_ff >= (i_slow ? 4 : 0)) begin
			o_ack   <= 1'b1;
			o_rdata <= i_addr[7:0] ^ {6'h00, i_space};
			if (i_we) begin
				o_nwr   <= o_nwr + 1;
				o_waddr <= i_addr;
				o_wdata <= i_wdata;
			end
		end else begin
			o_ack   <= 1'b0;
			wait_ff <= i_req ? wait_ff + 1 : 0;
			// read data only good in the ack cycle
			o_rdata <= ~o_rdata;
		end
	end
endmodule
`default_nettype wire

// ---- tb/dbgma_core_tb.sv ----
// self-checking bench for the debug memory-access core
`timescale 1ns/1ps
`default_nettype none
`include "dbgma_map.vh"
module dbgma_core_tb;
	typedef struct packed {
		logic [1:0]  ctl;
		logic [7:0]  op;
		logic [15:0] a;
		logic [15:0] sz;
		logic        unl;
		logic        ok;
	} dbgma_row_t;
	localparam logic [11:0] ct = `DBGMA_REG_CTRL;
	localparam logic [11:0] fc = `DBGMA_REG_FCTL;
	localparam logic [11:0] ps = `DBGMA_REG_PGSEL;
	logic        i_mclk = 0, i_nrst = 0, i_psel = 0, i_penable = 0;
	logic        i_pwrite = 0, i_rx_valid = 0, i_tx_ready = 0, slow = 0;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, r;
	logic [7:0]  i_rx_data = 0;
	wire  [31:0] o_prdata;
	wire         o_pready, o_pslverr, o_rx_ready, o_tx_valid;
	wire         o_mem_req, o_mem_we, i_mem_ack, o_erase_req;
	wire  [7:0]  o_tx_data, o_mem_wdata, i_mem_rdata, wdat;
	wire  [1:0]  o_mem_space;
	wire  [15:0] o_mem_addr, o_erase_addr, waddr;
	logic [15:0] ea;
	logic        e;
	logic [1:0]  wsp;
	int          nwr, fails = 0, n_checks = 0, ne = 0;
	dbgma_row_t  rows [8] = '{
		'{2'h1, 8'h09, 16'h0123, 16'h0003, 1'b0, 1'b1},
		'{2'h3, 8'h09, 16'h0040, 16'h0002, 1'b0, 1'b0},
		'{2'h0, 8'h0b, 16'h1000, 16'h0002, 1'b0, 1'b0},
		'{2'h1, 8'h0b, 16'h00fe, 16'h0004, 1'b0, 1'b1},
		'{2'h1, 8'h0c, 16'h2000, 16'h0002, 1'b0, 1'b1},
		'{2'h3, 8'h0c, 16'h2100, 16'h0001, 1'b0, 1'b0},
		'{2'h1, 8'h0a, 16'h0300, 16'h0101, 1'b0, 1'b0},
		'{2'h1, 8'h0a, 16'h0400, 16'h0003, 1'b1, 1'b1}};

	always #25 i_mclk = ~i_mclk;
	dbgma_core dbgma_core_i (.*);
	dbgma_mem_model dbgma_mem_model_i (.i_mclk, .i_nrst, .i_slow(slow),
		.i_req(o_mem_req), .i_we(o_mem_we), .i_space(o_mem_space),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata),
		.o_ack(i_mem_ack), .o_nwr(nwr), .o_waddr(waddr), .o_wdata(wdat));
	always @(posedge i_mclk) begin
		if (o_erase_req) begin
			ne++;
			ea = o_erase_addr;
		end
		// space of the last write actually presented to memory
		if (o_mem_req && o_mem_we)
			wsp = o_mem_space;
	end

	// ============
	// bus tasks
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge i_mclk);
		i_psel   <= 1;
		i_pwrite <= w;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1;
		do @(posedge i_mclk); while (!o_pready);
		r = o_prdata;
		e = o_pslverr;
		i_psel    <= 0;
		i_penable <= 0;
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge i_mclk);
		i_rx_data  <= b;
		i_rx_valid <= 1;
		do @(posedge i_mclk); while (!o_rx_ready);
		i_rx_valid <= 0;
		i_rx_data  <= ~b;
	endtask
	task automatic take(output logic [7:0] b);
		@(posedge i_mclk);
		i_tx_ready <= 1;
		do @(posedge i_mclk); while (!o_tx_valid);
		b = o_tx_data;
		i_tx_ready <= 0;
	endtask
	task automatic st(input logic [11:0] a, input logic [7:0] d,
			input logic [5:0] x);
		apb(1, a, d);
		apb(0, fc, 0);
		chk("status", r[5:0], x);
	endtask
	task automatic unlock;
		st(fc, `DBGMA_UNLOCK1, `DBGMA_FS_FIRST);
		st(fc, `DBGMA_UNLOCK2, `DBGMA_FS_UNLOCKED);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [15:0] a, sz,
			input logic ok, input int hold);
		int n;
		int w;
		logic rd;
		logic [7:0] b;
		logic [15:0] ai;
		logic [1:0] x;
		rd = op == `DBGMA_OP_RD_REG || op == `DBGMA_OP_RD_PROG;
		n = sz != 0 ? sz : op == `DBGMA_OP_RD_REG ? 256 : 65536;
		w = nwr;
		send(op);
		send(op == `DBGMA_OP_RD_REG ? {4'h0, a[11:8]} : a[15:8]);
		send(a[7:0]);
		if (op != `DBGMA_OP_RD_REG)
			send(sz[15:8]);
		send(sz[7:0]);
		repeat (hold) @(posedge i_mclk);
		if (hold > 0)
			chk("rx held", o_rx_ready, 0);
		for (int i = 0; i < n; i++) begin
			ai = a + i[15:0];
			if (rd) begin
				take(b);
				chk("rdata", b, ok ? ai[7:0] ^ op[1] : 8'hff);
			end else
				send(ai[7:0] ^ 8'h5a);
		end
		for (int k = 0; k < 20 && nwr - w != (ok && !rd ? n : 0); k++)
			@(posedge i_mclk);
		chk("writes", nwr - w, ok && !rd ? n : 0);
		if (ok && !rd) begin
			x = op == `DBGMA_OP_WR_DATA ? `DBGMA_SP_DATA : `DBGMA_SP_PROG;
			chk("last", {waddr, wdat}, {ai, ai[7:0] ^ 8'h5a});
			chk("space", wsp, x);
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ============
	// sequence
	initial begin
		repeat (16) @(posedge i_mclk);
		chk("pready", o_pready, 1);
		chk("rx idle", o_rx_ready, 1);
		chk("tx idle", o_tx_valid, 0);
		i_nrst <= 1;
		apb(0, ct, 0);
		chk("ctrl", r, `DBGMA_CTRL_RST);
		apb(0, 12'h010, 0);
		chk("unmapped", {r[30:0], e}, 1);
		foreach (rows[i]) begin
			apb(1, ct, rows[i].ctl);
			if (rows[i].unl)
				unlock();
			cmd(rows[i].op, rows[i].a, rows[i].sz, rows[i].ok, 0);
			apb(1, fc, 0);
		end
		st(fc, `DBGMA_UNLOCK1, `DBGMA_FS_FIRST);
		st(fc, 8'h11, `DBGMA_FS_LOCKED);
		unlock();
		st(ps, `DBGMA_SECT_SEL, `DBGMA_FS_SECTOR);
		st(ps, 8'h2a, `DBGMA_FS_UNLOCKED);
		apb(1, ps, 8'h85);
		st(fc, `DBGMA_PAGE_ERASE, `DBGMA_FS_LOCKED);
		chk("erase", {ne[7:0], ea}, 24'h010a00);
		// outside debug the page select write finishes the unlock
		apb(1, ct, 0);
		st(fc, `DBGMA_UNLOCK1, `DBGMA_FS_FIRST);
		st(fc, `DBGMA_UNLOCK2, `DBGMA_FS_SECOND);
		st(ps, 8'h01, `DBGMA_FS_UNLOCKED);
		// reset in mid-run drops the unlock and the page select
		@(posedge i_mclk);
		i_nrst <= 0;
		@(posedge i_mclk);
		i_nrst <= 1;
		apb(0, fc, 0);
		chk("reset status", r[5:0], `DBGMA_FS_LOCKED);
		apb(0, ps, 0);
		chk("reset page", r, `DBGMA_PGSEL_RST);
		apb(0, `DBGMA_REG_STAT, 0);
		chk("stat", r, 32'h00000042);
		st(fc, 0, `DBGMA_FS_LOCKED);
		// 256 bytes with replies stalled until the buffer refuses
		apb(1, ct, 1);
		slow <= 1;
		cmd(`DBGMA_OP_RD_REG, 16'h0f80, 0, 1, 400);
		slow <= 0;
		repeat (8) @(posedge i_mclk);
		chk("extra", o_tx_valid, 0);
		cmd(`DBGMA_OP_WR_DATA, 16'hffff, 1, 1, 0);
		tally_and_finish();
	end
	initial begin
		repeat (40000) @(posedge i_mclk);
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
